// file: pmw_ctrl.sv
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module pmw_ctrl #(
  parameter int unsigned PLL_LOCK_CYCLES = pmw_pkg::PLL_LOCK_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [pmw_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_usb2_dp,
  input wire logic i_usb2_dm,
  input wire logic i_id_pin_sense,
  input wire logic i_vbus_detect,
  input wire logic i_usb3_receive_pair_resume,
  input wire logic i_uart_cts,
  input wire logic i_parallel_port_control0,
  input wire logic i_hard_reset_b,
  output pmw_pkg::pmw_pwr_s o_pwr,
  output logic o_pc_reset,
  output logic o_device_restart
);
  import pmw_pkg::*;

  localparam int CHK_WAKE_MAX = 1000;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // wake sources that each low-power state listens to
  function automatic logic [7:0] allowed_mask(input pmw_state_e st);
    logic [7:0] m;
    m = 8'h00;
    case (st)
      ST_SUSPEND_PHY_ON: m = MASK_L1;
      ST_SUSPEND_PHY_OFF: m = MASK_L2;
      ST_STANDBY_STATE: m = MASK_L3;
      ST_CORE_POWER_DOWN: m = MASK_L4;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // power control pattern per state
  function automatic pmw_pwr_s state_ctrl(input pmw_state_e st);
    pmw_pwr_s p;
    p = pmw_pwr_s'(PWR_NORMAL);
    case (st)
      ST_NORMAL: p = pmw_pwr_s'(PWR_NORMAL);
      ST_SUSPEND_PHY_ON: p = pmw_pwr_s'(PWR_SUSP_PHY_ON);
      ST_SUSPEND_PHY_OFF: p = pmw_pwr_s'(PWR_SUSP_PHY_OFF);
      ST_STANDBY_STATE: p = pmw_pwr_s'(PWR_STANDBY);
      ST_CORE_POWER_DOWN: p = pmw_pwr_s'(PWR_CORE_DOWN);
      ST_WAKE_PLL: p = pmw_pwr_s'(PWR_WAKE_PLL);
      ST_WAKE_CLK: p = pmw_pwr_s'(PWR_WAKE_CLK);
      default: p = pmw_pwr_s'(PWR_NORMAL);
    endcase
    return p;
  endfunction

  // merge write data into a register under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pins;
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] st_q;
  logic [7:0] st_d;
  logic [7:0] prev_q;
  logic [7:0] agree;
  logic [7:0] chg;

  assign pins = {i_hard_reset_b, i_parallel_port_control0, i_uart_cts,
                 i_usb3_receive_pair_resume, i_vbus_detect, i_id_pin_sense,
                 i_usb2_dm, i_usb2_dp};

  // three flops per pin; a level counts once stages two and three agree
  genvar g;
  for (g = 0; g < NUM_WAKE; g++) begin : g_sync
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        s1_q[g] <= PIN_RST[g];
        s2_q[g] <= PIN_RST[g];
        s3_q[g] <= PIN_RST[g];
        st_q[g] <= PIN_RST[g];
        prev_q[g] <= PIN_RST[g];
      end else begin
        s1_q[g] <= pins[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        st_q[g] <= st_d[g];
        prev_q[g] <= st_q[g];
      end
    end
  end

  // filtered level and its change
  assign agree = ~(s2_q ^ s3_q);
  assign st_d = (agree & s3_q) | (~agree & st_q);
  assign chg = st_q ^ prev_q;

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  logic wait_q;
  logic [31:0] rdata_q;
  logic acc_wr;
  logic acc_rd;
  logic [31:0] wake_en_q;
  logic [7:0] cause_q;
  logic src_mbox_q;
  pmw_state_e state_q;
  pmw_state_e state_d;
  logic [31:0] rd_mux;
  logic hit_cpu;
  logic hit_mbox;
  logic hit_en;
  logic hit_stat;
  logic hit_cause;

  // address decode
  assign hit_cpu = (i_avs_address == OFF_CPU_REQ);
  assign hit_mbox = (i_avs_address == OFF_MBOX_REQ);
  assign hit_en = (i_avs_address == OFF_WAKE_EN);
  assign hit_stat = (i_avs_address == OFF_STATUS);
  assign hit_cause = (i_avs_address == OFF_WAKE_CAUSE);
  // a write takes effect at the edge where waitrequest is seen low
  assign acc_wr = i_avs_write && !wait_q;
  assign acc_rd = i_avs_read && wait_q;

  // read mux; unmapped and request registers read zero
  assign rd_mux = hit_en ? (wake_en_q & 32'h0000_01FF) :
                  hit_stat ? {23'h0, src_mbox_q, 1'b0, state_q} :
                  hit_cause ? {24'h0, cause_q} : 32'h0000_0000;

  // one wait cycle per access, then the answer for one edge
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((i_avs_read || i_avs_write) && wait_q);
      if (acc_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // suspend requests from firmware and the mailbox
  // ----------------------------------------------------------------
  logic req_fire;
  logic mbox_fire;
  pmw_mode_e req_mode;

  // the device keeps no record of open transactions
  assign req_fire = acc_wr && (hit_cpu || hit_mbox) && i_avs_byteenable[0]
                    && i_avs_writedata[REQ_GO_BIT];
  assign mbox_fire = req_fire && hit_mbox;
  assign req_mode = pmw_mode_e'(i_avs_writedata[REQ_MODE_LSB +: 2]);

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  logic [7:0] wake_ev;
  logic [7:0] wake_en_eff;
  logic [7:0] wake_hits;
  logic wake_go;
  logic rst_hit;
  logic cts_pol;

  assign cts_pol = wake_en_q[CTS_POL_BIT];
  // per-source wake conditions
  assign wake_ev[WK_DP] = chg[WK_DP];
  assign wake_ev[WK_DM] = chg[WK_DM];
  assign wake_ev[WK_ID] = chg[WK_ID];
  assign wake_ev[WK_VBUS] = st_q[WK_VBUS];
  assign wake_ev[WK_RX] = st_q[WK_RX];
  assign wake_ev[WK_CTS] = st_q[WK_CTS] ~^ cts_pol;
  assign wake_ev[WK_CTL0] = st_q[WK_CTL0];
  assign wake_ev[WK_RST] = ~st_q[WK_RST];
  // the hard-reset wake cannot be masked
  assign wake_en_eff = {1'b1, wake_en_q[6:0]};
  assign wake_hits = wake_ev & wake_en_eff & allowed_mask(state_q);
  assign wake_go = |wake_hits;
  assign rst_hit = wake_hits[WK_RST];

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [7:0] cause_set;
  logic [7:0] cause_clr;

  assign cause_set = wake_hits;
  assign cause_clr = (acc_wr && hit_cause && i_avs_byteenable[0]) ?
                     i_avs_writedata[7:0] : 8'h00;

  // enables, last requester and sticky wake cause (set beats clear)
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wake_en_q <= WAKE_EN_RST;
      src_mbox_q <= 1'b0;
      cause_q <= 8'h00;
    end else begin
      if (acc_wr && hit_en) begin
        wake_en_q <= be_merge(wake_en_q, i_avs_writedata, i_avs_byteenable);
      end
      if (req_fire && state_q == ST_NORMAL) begin
        src_mbox_q <= hit_mbox;
      end
      cause_q <= (cause_q & ~cause_clr) | cause_set;
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic lock_done;
  logic pcr_pend_q;
  logic rst_pend_q;

  assign lock_done = (cnt_q >= 16'(PLL_LOCK_CYCLES - 1));

  // state transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (req_fire) begin
          case (req_mode)
            MODE_SUSPEND_PHY_ON: state_d = ST_SUSPEND_PHY_ON;
            MODE_SUSPEND_PHY_OFF: state_d = ST_SUSPEND_PHY_OFF;
            MODE_STANDBY_STATE: state_d = ST_STANDBY_STATE;
            default: state_d = ST_CORE_POWER_DOWN;
          endcase
        end
      end
      ST_SUSPEND_PHY_ON, ST_SUSPEND_PHY_OFF, ST_STANDBY_STATE, ST_CORE_POWER_DOWN: begin
        if (wake_go) begin
          state_d = ST_WAKE_PLL;
        end
      end
      ST_WAKE_PLL: begin
        if (lock_done) begin
          state_d = ST_WAKE_CLK;
        end
      end
      ST_WAKE_CLK: state_d = ST_NORMAL;
      default: state_d = ST_NORMAL;
    endcase
  end

  // pll lock counter runs only while waking
  assign cnt_d = (state_q == ST_WAKE_PLL) ? cnt_q + 16'h0001 : 16'h0000;

  // state, lock counter and the kind of wake that is pending
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= ST_NORMAL;
      cnt_q <= 16'h0000;
      pcr_pend_q <= 1'b0;
      rst_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (wake_go && state_q != ST_NORMAL) begin
        pcr_pend_q <= (state_q == ST_STANDBY_STATE);
        rst_pend_q <= rst_hit;
      end else if (state_q == ST_NORMAL) begin
        pcr_pend_q <= 1'b0;
        rst_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  pmw_pwr_s pwr_q;
  logic pc_reset_q;
  logic restart_q;

  // power controls follow the next state so they change with the state
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_q <= pmw_pwr_s'(PWR_NORMAL);
      pc_reset_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      pwr_q <= state_ctrl(state_d);
      pc_reset_q <= (state_q == ST_WAKE_CLK) && pcr_pend_q && !rst_pend_q;
      restart_q <= (state_q == ST_WAKE_CLK) && rst_pend_q;
    end
  end

  assign o_pwr = pwr_q;
  assign o_pc_reset = pc_reset_q;
  assign o_device_restart = restart_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  chk_normal_clocks_run: assert property (
    state_q == ST_NORMAL |-> pwr_q.cpu_clk_en && pwr_q.pll_en && !pwr_q.io_hold)
    else $error("normal mode without cpu clock or pll");
  chk_core_down_entry: assert property (
    state_q == ST_NORMAL && req_fire && req_mode == MODE_CORE_POWER_DOWN
    |=> state_q == ST_CORE_POWER_DOWN && pwr_q.core_power_off)
    else $error("power-down request not honoured");
  chk_phy_only_clock: assert property (
    state_q == ST_SUSPEND_PHY_ON |-> pwr_q.phy_en && pwr_q.phy_u3 && !pwr_q.cpu_clk_en
    && !pwr_q.pll_en && !pwr_q.periph_clk_en && !pwr_q.osc_en)
    else $error("suspend phy on clocks wrong");
  chk_io_hold_susp: assert property (
    state_q inside {ST_SUSPEND_PHY_ON, ST_SUSPEND_PHY_OFF, ST_WAKE_PLL, ST_WAKE_CLK}
    |-> pwr_q.io_hold)
    else $error("io hold dropped during suspend");
  chk_mem_retained: assert property (
    state_q inside {ST_SUSPEND_PHY_ON, ST_SUSPEND_PHY_OFF} |-> pwr_q.mem_retain)
    else $error("memory retention dropped in suspend");
  chk_resume_keeps_pc: assert property (
    state_q == ST_WAKE_CLK && !pcr_pend_q && !rst_pend_q
    |=> state_q == ST_NORMAL && !o_pc_reset && !o_device_restart)
    else $error("resume disturbed the program counter");
  chk_fw_suspend: assert property (
    state_q == ST_NORMAL && req_fire && !hit_mbox && req_mode == MODE_SUSPEND_PHY_ON
    |=> state_q == ST_SUSPEND_PHY_ON && pwr_q.phy_u3)
    else $error("firmware suspend request lost");
  chk_mbox_suspend: assert property (
    state_q == ST_NORMAL && mbox_fire |=> state_q != ST_NORMAL && src_mbox_q)
    else $error("mailbox suspend request lost");
  chk_dline_wake: assert property (
    state_q == ST_SUSPEND_PHY_ON && (chg[WK_DP] || chg[WK_DM]) && wake_en_q[WK_DP]
    && wake_en_q[WK_DM] |=> state_q == ST_WAKE_PLL && $past(wake_hits) != 8'h00)
    else $error("data line change did not wake");
  chk_vbus_wake: assert property (
    state_q == ST_STANDBY_STATE && st_q[WK_VBUS] && wake_en_q[WK_VBUS]
    |=> state_q == ST_WAKE_PLL ##1 cause_q[WK_VBUS])
    else $error("vbus did not wake standby");
  chk_rx_wake_l1_only: assert property (
    state_q == ST_SUSPEND_PHY_OFF && wake_ev == 8'h10 |=> state_q == ST_SUSPEND_PHY_OFF)
    else $error("receive pair woke suspend phy off");
  chk_cts_polarity: assert property (
    state_q == ST_SUSPEND_PHY_OFF && wake_en_q[WK_CTS] && st_q[WK_CTS] == cts_pol
    |=> state_q == ST_WAKE_PLL)
    else $error("cts level did not wake");
  chk_reset_restarts: assert property (
    state_q == ST_CORE_POWER_DOWN && !st_q[WK_RST]
    |-> ##[1:CHK_WAKE_MAX] o_device_restart)
    else $error("hard reset wake did not restart");
  chk_phy_off_clocks: assert property (
    state_q == ST_SUSPEND_PHY_OFF |-> !pwr_q.phy_en && !pwr_q.pll_en && !pwr_q.cpu_clk_en)
    else $error("suspend phy off left a clock running");
  chk_standby_pc_reset: assert property (
    state_q == ST_WAKE_CLK && pcr_pend_q && !rst_pend_q |=> o_pc_reset ##1 !o_pc_reset)
    else $error("standby wake without program counter reset");
  chk_wake_order: assert property (
    state_q == ST_WAKE_PLL |-> pwr_q.pll_en && !pwr_q.cpu_clk_en && pwr_q.io_hold
    ##[1:CHK_WAKE_MAX] state_q == ST_WAKE_CLK)
    else $error("wake skipped pll restart");

  cov_l1_round: cover property (state_q == ST_SUSPEND_PHY_ON ##1 state_q == ST_WAKE_PLL);
  cov_standby_wake: cover property (state_q == ST_WAKE_CLK && pcr_pend_q);
  cov_mbox_entry: cover property (state_q == ST_NORMAL && mbox_fire);
  cov_reset_wake: cover property (o_device_restart);
endmodule

// file: pmw_pkg.sv
package pmw_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CPU_REQ = 8'h00;
  localparam logic [7:0] OFF_MBOX_REQ = 8'h04;
  localparam logic [7:0] OFF_WAKE_EN = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_WAKE_CAUSE = 8'h10;
  localparam int REQ_GO_BIT = 0;
  localparam int REQ_MODE_LSB = 1;
  localparam int CTS_POL_BIT = 8;
  localparam int SRC_MBOX_BIT = 8;
  localparam logic [31:0] WAKE_EN_RST = 32'h0000_00FF;
  // ----------------------------------------------------------------
  // wake sources, index into the pin vector
  // ----------------------------------------------------------------
  localparam int NUM_WAKE = 8;
  localparam int WK_DP = 0;
  localparam int WK_DM = 1;
  localparam int WK_ID = 2;
  localparam int WK_VBUS = 3;
  localparam int WK_RX = 4;
  localparam int WK_CTS = 5;
  localparam int WK_CTL0 = 6;
  localparam int WK_RST = 7;
  localparam logic [7:0] PIN_RST = 8'hA0;
  localparam logic [7:0] MASK_L1 = 8'hFF;
  localparam logic [7:0] MASK_L2 = 8'hEF;
  localparam logic [7:0] MASK_L3 = 8'hE8;
  localparam logic [7:0] MASK_L4 = 8'h80;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PLL_LOCK_NS = 10000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_MIN_MS = 1;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SUSPEND_PHY_ON = 2'h0,
    MODE_SUSPEND_PHY_OFF = 2'h1,
    MODE_STANDBY_STATE = 2'h2,
    MODE_CORE_POWER_DOWN = 2'h3
  } pmw_mode_e;
  typedef enum logic [6:0] {
    ST_NORMAL = 7'h01,
    ST_SUSPEND_PHY_ON = 7'h02,
    ST_SUSPEND_PHY_OFF = 7'h04,
    ST_STANDBY_STATE = 7'h08,
    ST_CORE_POWER_DOWN = 7'h10,
    ST_WAKE_PLL = 7'h20,
    ST_WAKE_CLK = 7'h40
  } pmw_state_e;
  typedef struct packed {
    logic cpu_clk_en;
    logic pll_en;
    logic osc_en;
    logic periph_clk_en;
    logic phy_en;
    logic phy_u3;
    logic io_hold;
    logic mem_retain;
    logic core_power_off;
  } pmw_pwr_s;
  localparam logic [8:0] PWR_NORMAL = 9'h1F0;
  localparam logic [8:0] PWR_SUSP_PHY_ON = 9'h01E;
  localparam logic [8:0] PWR_SUSP_PHY_OFF = 9'h006;
  localparam logic [8:0] PWR_STANDBY = 9'h006;
  localparam logic [8:0] PWR_CORE_DOWN = 9'h001;
  localparam logic [8:0] PWR_WAKE_PLL = 9'h0D6;
  localparam logic [8:0] PWR_WAKE_CLK = 9'h1F6;
endpackage

// file: pmw_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external processor reaching the mailbox over avalon-mm
// ----------------------------------------------------------------
module pmw_host (
  input wire logic i_core_clk,
  input wire logic i_waitrequest,
  output logic [7:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  // idle bus at time zero
  initial begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0000_0000;
    o_byteenable = 4'h0;
  end

  // one access at a time, so nothing is outstanding at a request
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_read <= ~wr;
    o_write <= wr;
    o_address <= a;
    o_writedata <= d;
    o_byteenable <= 4'hF;
    @(posedge i_core_clk);
    while (i_waitrequest !== 1'b0) begin
      @(posedge i_core_clk);
    end
    o_read <= 1'b0;
    o_write <= 1'b0;
    o_writedata <= ~d; // released lines do not keep the last value
    o_byteenable <= 4'h0;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pmw_pkg::*;
  localparam int LOCK = 4;
  logic clk;
  logic rst_b;
  logic [7:0] pv;
  logic pol;
  logic [7:0] addr;
  logic rd_o;
  logic wr_o;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wq;
  pmw_pwr_s pwr;
  logic pc_rst;
  logic restart;
  int n_mismatch;
  int tests_run;
  int cyc;
  logic [31:0] exp_q[$];

  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  pmw_ctrl #(.PLL_LOCK_CYCLES(LOCK)) uut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd_o),
    .i_avs_write(wr_o), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_usb2_dp(pv[WK_DP]),
    .i_usb2_dm(pv[WK_DM]), .i_id_pin_sense(pv[WK_ID]), .i_vbus_detect(pv[WK_VBUS]),
    .i_usb3_receive_pair_resume(pv[WK_RX]), .i_uart_cts(pv[WK_CTS] ^ ~pol),
    .i_parallel_port_control0(pv[WK_CTL0]), .i_hard_reset_b(~pv[WK_RST]),
    .o_pwr(pwr), .o_pc_reset(pc_rst), .o_device_restart(restart)
  );

  pmw_host host (
    .i_core_clk(clk), .i_waitrequest(wq), .o_address(addr), .o_read(rd_o),
    .o_write(wr_o), .o_writedata(wdata), .o_byteenable(be)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // read data taken at the accepting edge against the oldest note
  always @(posedge clk) begin
    if (rd_o && wq === 1'b0) begin
      if (exp_q.size() == 0) chk(rdata, 32'hDEAD_0000);
      else chk(rdata, exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // one suspend and wake round
  // ----------------------------------------------------------------
  task automatic run(input int m, input int k, input int bad, input logic mb);
    logic [8:0] sp;
    int n;
    sp = m == 0 ? PWR_SUSP_PHY_ON : m == 1 ? PWR_SUSP_PHY_OFF :
         m == 2 ? PWR_STANDBY : PWR_CORE_DOWN;
    host.xfer(1'b1, mb ? OFF_MBOX_REQ : OFF_CPU_REQ, 32'(m * 2 + 1));
    @(negedge clk);
    chk(pwr, sp);
    if (bad < 8) begin
      @(posedge clk) pv[bad] <= ~pv[bad];
      repeat (10) @(negedge clk);
      chk(pwr, sp);
    end
    @(posedge clk) pv[k] <= ~pv[k];
    n = 0;
    while (pwr !== PWR_WAKE_PLL && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(pwr, PWR_WAKE_PLL);
    n = 0;
    while (pwr === PWR_WAKE_PLL && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(32'(n), LOCK);
    chk(pwr, PWR_WAKE_CLK);
    @(negedge clk);
    chk(pwr, PWR_NORMAL);
    chk(pc_rst, m == 2 && k != WK_RST);
    chk(restart, k == WK_RST);
    @(posedge clk) pv[k] <= ~pv[k];
    if (bad < 8) pv[bad] <= ~pv[bad];
    repeat (8) @(posedge clk);
    rd(OFF_STATUS, 32'({mb, 8'h01}));
    rd(OFF_WAKE_CAUSE, 32'h0000_0001 << k);
    host.xfer(1'b1, OFF_WAKE_CAUSE, 32'h0000_00FF);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] mk;
    int m;
    int k;
    int bad;
    rst_b = 1'b0;
    pv = 8'h00;
    pol = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    void'($urandom(32'h9a42));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(pwr, PWR_NORMAL);
    rd(OFF_WAKE_EN, WAKE_EN_RST);
    host.xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    rd(OFF_CPU_REQ, 32'h0000_0000);
    // every mode in turn, then random rounds
    for (int i = 0; i < 16; i++) begin
      m = i < 4 ? i : int'($urandom % 4);
      mk = m == 0 ? MASK_L1 : m == 1 ? MASK_L2 : m == 2 ? MASK_L3 : MASK_L4;
      do k = int'($urandom % 8); while (!mk[k]);
      bad = 8;
      if (mk != 8'hFF) begin
        do bad = int'($urandom % 8); while (mk[bad]);
      end
      run(m, k, bad, i[0]);
    end
    // active-high clear-to-send, then only the reset pin enabled
    host.xfer(1'b1, OFF_WAKE_EN, 32'h0000_01FF);
    @(posedge clk) pol <= 1'b1;
    rd(OFF_WAKE_EN, 32'h0000_01FF);
    run(0, WK_CTS, 8, 1'b0);
    host.xfer(1'b1, OFF_WAKE_EN, 32'h0000_0000);
    rd(OFF_WAKE_EN, 32'h0000_0000);
    run(0, WK_RST, WK_DP, 1'b1);
    repeat (4) @(posedge clk);
    chk(32'(exp_q.size()), 32'h0000_0000);
    conclude();
  end
endmodule
